// ### pkg/thermo_defines.svh
/*
   Constants of the thermocouple input channel link: register indices,
   reset values, control and status byte fields, the frame divider and
   the controller's own Avalon register map.
   Assumes it is included by its bare name; the guard makes repeat inclusion harmless.
*/
`ifndef THERMO_DEFINES_SVH
`define THERMO_DEFINES_SVH

// Number of channels carried in one process image.
`define NUM_CH 2
// Width of a channel index.
`define CH_IDX_W 1

// Register indices selected by the six-bit address field.
`define REG_TYPE_CODE 6'h08
`define REG_OFFSET_COMP 6'h11
`define REG_GAIN_COMP 6'h12
`define REG_REF_GAIN 6'h15
`define REG_CODE_WORD 6'h1f
`define REG_FEATURE 6'h20

// Reset values of the device registers.
`define RST_FEATURE 16'h1006
`define RST_OFFSET 16'h0000
`define RST_GAIN 16'h0100
`define RST_REF_GAIN 16'h0100
`define RST_CODE_WORD 16'h0000
// Code word value that opens the compensation registers for writing.
`define UNLOCK_VALUE 16'h1235
// Feature bit that selects manufacturer scaling.
`define FEAT_MFR_SCALE 1

// Control byte fields.
`define CTRL_REG_BIT 7
`define CTRL_WRITE_BIT 6
// Status byte fields.
`define STAT_ERR_BIT 6
`define STAT_OVER_BIT 1
`define STAT_UNDER_BIT 0

// Reference clock cycles between two output image frames.
`define FRAME_DIV 8'd16

// Controller register byte offsets on the Avalon bus.
`define AV_CMD 5'h00
`define AV_WDATA 5'h04
`define AV_STATUS 5'h08
`define AV_CFG 5'h0c
`define AV_IRQ_STAT 5'h10
`define AV_IRQ_MASK 5'h14
`define AV_PDATA0 5'h18
`define AV_PDATA1 5'h1c
// Command register fields.
`define CMD_WRITE_BIT 6
`define CMD_CHAN_BIT 8
`define CMD_START_BIT 31
// Interrupt status layout: done first, then one error bit per channel.
`define IRQ_W 3
`define IRQ_DONE 0
`define IRQ_ERR0 1

`endif

// ### pkg/thermo_link_if.sv
/*
   Process image link between the bus coupler side and the input channels.
   Assumes both ends run on the same clock; no clock travels here.
*/
`timescale 1ns/1ps

interface thermo_link_if;
   import thermo_pkg::*;

   // Output image from the coupler, valid for one cycle with out_valid.
   image_t out_image;
   logic out_valid;
   // Coupler mapping choices: word alignment and big-endian order.
   logic align;
   logic big_end;
   // Input image from the channels, valid for one cycle with in_valid.
   image_t in_image;
   logic in_valid;

   // The channel end.
   modport dev (
      input out_image, out_valid, align, big_end,
      output in_image, in_valid
   );

   // The coupler end.
   modport ctl (
      output out_image, out_valid, align, big_end,
      input in_image, in_valid
   );

endinterface : thermo_link_if

// ### pkg/thermo_pkg.sv
/*
   Types and byte-placement helpers shared by both ends of the link.
   Assumes the defines header sits beside it on the include path.
*/
`include "thermo_defines.svh"

package thermo_pkg;

   // One process image byte.
   typedef logic [7:0] byte_t;
   // One channel slot: head byte at index 0, then three more bytes.
   typedef byte_t [3:0] slot_t;
   // A whole process image, one slot per channel.
   typedef slot_t [`NUM_CH-1:0] image_t;
   // One 16-bit word per channel.
   typedef logic [`NUM_CH-1:0][15:0] word_arr_t;
   // Controller command state.
   typedef enum logic [0:0] {
      st_idle = 1'b0,
      st_wait = 1'b1
   } ctl_state_t;

   // Recovers the 16-bit value that follows the head byte of a slot.
   function automatic logic [15:0] slot_data(input slot_t s, input logic align,
                                             input logic big_end);
      byte_t first;
      byte_t second;
      first = align ? s[2] : s[1];
      second = align ? s[3] : s[2];
      return big_end ? {first, second} : {second, first};
   endfunction : slot_data

endpackage : thermo_pkg

// ### rtl/chan_slot_packer.sv
/*
   Places a head byte and a 16-bit value into one channel slot.
   Assumes the caller registers the slot; this is pure logic.
*/
`timescale 1ns/1ps

module chan_slot_packer
   import thermo_pkg::*;
(
   input wire byte_t head_i,
   input wire logic [15:0] word_i,
   input wire logic align_i,
   input wire logic big_end_i,
   output slot_t slot_o
);

   // Byte that lands at the lower address, and the one after it.
   byte_t first;
   byte_t second;

   // Big-endian puts the high byte first, otherwise the low byte.
   always_comb begin
      first = big_end_i ? word_i[15:8] : word_i[7:0];
      second = big_end_i ? word_i[7:0] : word_i[15:8];
   end

   // Head byte always first; aligned slots leave a reserved zero byte after it.
   always_comb begin
      slot_o[0] = head_i;
      if (align_i) begin
         slot_o[1] = 8'h00;
         slot_o[2] = first;
         slot_o[3] = second;
      end else begin
         slot_o[1] = first;
         slot_o[2] = second;
         slot_o[3] = 8'h00;
      end
   end

endmodule : chan_slot_packer

// ### rtl/thermo_ctl_end.sv
/*
   Coupler end of the thermocouple input link: sends output frames at a
   fixed rate, runs one register command at a time and collects process
   data. Software reaches it over an Avalon-MM slave with waitrequest.
   Assumes the channel end answers each frame on the same clock.
*/
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps

module thermo_ctl_end
   import thermo_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [4:0] av_address_i,
   input wire logic av_read_i,
   input wire logic av_write_i,
   input wire logic [31:0] av_writedata_i,
   output logic [31:0] av_readdata_o,
   output logic av_waitrequest_o,
   output logic irq_o,
   thermo_link_if.ctl link
);

   // Command fields; all but the write data are held while a command runs.
   ctl_state_t state;
   logic [5:0] cmd_addr;
   logic cmd_write;
   logic [`CH_IDX_W-1:0] cmd_chan;
   logic [15:0] cmd_wdata;
   // Answer of the last command.
   byte_t last_stat;
   logic [15:0] rdata;
   // Mapping choices handed to the link.
   logic align;
   logic big_end;
   // Interrupt status and mask.
   logic [`IRQ_W-1:0] irq_stat;
   logic [`IRQ_W-1:0] irq_mask;
   logic [`IRQ_W-1:0] irq_set;
   // Latest process data per channel: status byte and value.
   byte_t [`NUM_CH-1:0] p_stat;
   word_arr_t p_data;
   // Frame divider and its one-cycle enable.
   logic [7:0] div_cnt;
   wire logic tick = (div_cnt == `FRAME_DIV - 8'd1);
   // Slots to be sent.
   image_t next_out;
   // Bus access taken at this edge.
   wire logic acc = (av_read_i | av_write_i) & ~av_waitrequest_o;
   wire logic wr_acc = av_write_i & ~av_waitrequest_o;
   // Answer that completes the command: address with bit 7 set.
   wire byte_t ack_stat = {2'b10, cmd_addr};
   wire logic done = (state == st_wait) && link.in_valid &&
                     link.in_image[cmd_chan][0] == ack_stat;

   // Frame rate divider.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      end
   end

   // Only the commanded channel carries register mode; others send zero.
   genvar c;
   generate
      for (c = 0; c < `NUM_CH; c++) begin : g_ch
         wire logic sel = (state == st_wait) && (cmd_chan == c);
         chan_slot_packer u_pack (
            .head_i(sel ? {1'b1, cmd_write, cmd_addr} : 8'h00),
            .word_i(sel ? cmd_wdata : 16'h0000),
            .align_i(align),
            .big_end_i(big_end),
            .slot_o(next_out[c])
         );
      end
   endgenerate

   // Output frames leave on each divider tick.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         link.out_image <= '0;
         link.out_valid <= 1'b0;
      end else begin
         link.out_valid <= tick;
         if (tick) begin
            link.out_image <= next_out;
         end
      end
   end

   // Command engine; a start while busy is ignored.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state <= st_idle;
         cmd_addr <= 6'h00;
         cmd_write <= 1'b0;
         cmd_chan <= '0;
         last_stat <= 8'h00;
         rdata <= 16'h0000;
      end else begin
         case (state)
            st_idle: begin
               if (wr_acc && av_address_i == `AV_CMD && av_writedata_i[`CMD_START_BIT]) begin
                  state <= st_wait;
                  cmd_addr <= av_writedata_i[5:0];
                  cmd_write <= av_writedata_i[`CMD_WRITE_BIT];
                  cmd_chan <= av_writedata_i[`CMD_CHAN_BIT];
               end
            end
            st_wait: begin
               // The access only ends once the acknowledgement comes back.
               if (done) begin
                  state <= st_idle;
                  last_stat <= link.in_image[cmd_chan][0];
                  rdata <= slot_data(link.in_image[cmd_chan], align, big_end);
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // Software registers: write data, mapping choices and interrupt mask.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cmd_wdata <= 16'h0000;
         align <= 1'b0;
         big_end <= 1'b0;
         irq_mask <= '0;
      end else if (wr_acc) begin
         case (av_address_i)
            `AV_WDATA: cmd_wdata <= av_writedata_i[15:0];
            `AV_CFG: begin
               align <= av_writedata_i[0];
               big_end <= av_writedata_i[1];
            end
            `AV_IRQ_MASK: irq_mask <= av_writedata_i[`IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // The channel end reads the mapping choices straight from these flops.
   assign link.align = align;
   assign link.big_end = big_end;

   // Process data of channels not busy with a register command.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         p_stat <= '0;
         p_data <= '0;
      end else if (link.in_valid) begin
         for (int i = 0; i < `NUM_CH; i++) begin
            if (!link.in_image[i][0][7]) begin
               p_stat[i] <= link.in_image[i][0];
               p_data[i] <= slot_data(link.in_image[i], align, big_end);
            end
         end
      end
   end

   // Events: command done and a channel error seen in process data.
   always_comb begin
      irq_set = '0;
      irq_set[`IRQ_DONE] = done;
      for (int i = 0; i < `NUM_CH; i++) begin
         irq_set[`IRQ_ERR0 + i] = link.in_valid & ~link.in_image[i][0][7] &
                                  link.in_image[i][0][`STAT_ERR_BIT];
      end
   end

   // Sticky status, write one to clear; a new event beats the clear.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         irq_stat <= '0;
         irq_o <= 1'b0;
      end else begin
         if (wr_acc && av_address_i == `AV_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~av_writedata_i[`IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // One wait state: waitrequest drops for one cycle with read data ready.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         av_waitrequest_o <= 1'b1;
         av_readdata_o <= 32'h0000_0000;
      end else begin
         av_waitrequest_o <= ~((av_read_i | av_write_i) & av_waitrequest_o);
         if (av_read_i && av_waitrequest_o) begin
            case (av_address_i)
               `AV_CMD: av_readdata_o <= {23'h000000, cmd_chan, 1'b0, cmd_write, cmd_addr};
               `AV_WDATA: av_readdata_o <= {16'h0000, cmd_wdata};
               `AV_STATUS: av_readdata_o <= {rdata, last_stat, 7'h00, state == st_wait};
               `AV_CFG: av_readdata_o <= {30'h00000000, big_end, align};
               `AV_IRQ_STAT: av_readdata_o <= {29'h00000000, irq_stat};
               `AV_IRQ_MASK: av_readdata_o <= {29'h00000000, irq_mask};
               `AV_PDATA0: av_readdata_o <= {8'h00, p_stat[0], p_data[0]};
               `AV_PDATA1: av_readdata_o <= {8'h00, p_stat[1], p_data[1]};
               default: av_readdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : thermo_ctl_end

// ### rtl/thermo_dev_end.sv
/*
   Channel end of the thermocouple input link: status byte generation,
   register access carried in the process image and the compensation
   register set handed to the converter.
   Assumes the coupler end drives the link on the same clock and that the
   converter supplies measurements and range flags on that clock too.
*/
// Summary of operation
// - Control byte ignored outside register mode.
// - Status bit 7 low, bit 6 error.
// - Bits 5-2 reserved, over range, under range.
// - Control bit 7 turns data into register transfer.
// - Bit 6 clear reads register unchanged.
// - Bit 6 set writes; done on acknowledgement.
// - Six address bits select 64 registers.
// - Head byte first, two data bytes follow.
// - Word alignment inserts one reserved byte.
// - Register 8 returns type code, echoes control.
// - Write acknowledged with address and bit 7.
// - Code word write returns zero data.
// - Channel uses both input and output images.
// - Offset trim uses feature value for raw input.
// - Unscaled voltage reported at 4 uV per digit.
// - Offset and gain trims held per channel.
// - Reference trim needs type and compensation active.
// - Reference gain shared by all channels.
`timescale 1ns/1ps

module thermo_dev_end
   import thermo_pkg::*;
#(
   // Terminal type code returned by register 8; the value is arbitrary.
   parameter logic [15:0] TYPE_CODE = 16'h1234
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   thermo_link_if.dev link,
   input wire word_arr_t meas_raw_i,
   input wire word_arr_t meas_scaled_i,
   input wire logic [`NUM_CH-1:0] err_i,
   input wire logic [`NUM_CH-1:0] over_i,
   input wire logic [`NUM_CH-1:0] under_i,
   output word_arr_t offset_comp_o,
   output word_arr_t gain_comp_o,
   output word_arr_t feature_o,
   output logic [15:0] ref_gain_o,
   output logic unlocked_o
);

   // Code word register, shared by all channels.
   logic [15:0] code_word;
   // Per channel control byte as received.
   byte_t [`NUM_CH-1:0] ctrl;
   // Per channel value that follows the control byte.
   word_arr_t wdata;
   // Per channel register write request for this frame.
   logic [`NUM_CH-1:0] wr_en;
   // Per channel register read result.
   word_arr_t rdval;
   // Per channel answer head byte and value.
   byte_t [`NUM_CH-1:0] stat;
   word_arr_t dval;
   // Answer image before it is registered onto the link.
   image_t next_image;

   // Compensation writes are only taken while the code word is open.
   wire logic open_w = (code_word == `UNLOCK_VALUE);

   genvar c;
   generate
      for (c = 0; c < `NUM_CH; c++) begin : g_ch
         // Split the slot; the head byte only matters in register mode.
         always_comb begin
            ctrl[c] = link.out_image[c][0];
            wdata[c] = slot_data(link.out_image[c], link.align, link.big_end);
            wr_en[c] = link.out_valid & ctrl[c][`CTRL_REG_BIT] &
                       ctrl[c][`CTRL_WRITE_BIT];
         end

         // Register read decode; unmapped addresses read as zero.
         always_comb begin
            case (ctrl[c][5:0])
               `REG_TYPE_CODE: rdval[c] = TYPE_CODE;
               `REG_OFFSET_COMP: rdval[c] = offset_comp_o[c];
               `REG_GAIN_COMP: rdval[c] = gain_comp_o[c];
               `REG_REF_GAIN: rdval[c] = ref_gain_o;
               `REG_CODE_WORD: rdval[c] = code_word;
               `REG_FEATURE: rdval[c] = feature_o[c];
               default: rdval[c] = 16'h0000;
            endcase
         end

         // Build the answer for this channel.
         always_comb begin
            if (ctrl[c][`CTRL_REG_BIT]) begin
               if (ctrl[c][`CTRL_WRITE_BIT]) begin
                  // Write answer: address with bit 7 set, bit 6 clear, no data.
                  stat[c] = {2'b10, ctrl[c][5:0]};
                  dval[c] = 16'h0000;
               end else begin
                  // Read answer echoes the control byte and carries the value.
                  stat[c] = ctrl[c];
                  dval[c] = rdval[c];
               end
            end else begin
               // Process data: the rest of the control byte plays no part.
               stat[c] = 8'h00;
               stat[c][7] = 1'b0;
               stat[c][`STAT_ERR_BIT] = err_i[c];
               stat[c][`STAT_OVER_BIT] = over_i[c];
               stat[c][`STAT_UNDER_BIT] = under_i[c];
               // Without manufacturer scaling the raw 4 uV count goes out.
               dval[c] = feature_o[c][`FEAT_MFR_SCALE] ? meas_scaled_i[c]
                                                       : meas_raw_i[c];
            end
         end

         // Place head byte and value into the slot as the coupler maps it.
         chan_slot_packer u_pack (
            .head_i(stat[c]),
            .word_i(dval[c]),
            .align_i(link.align),
            .big_end_i(link.big_end),
            .slot_o(next_image[c])
         );

         // Per channel trims, each written only through its own slot.
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               offset_comp_o[c] <= `RST_OFFSET;
               gain_comp_o[c] <= `RST_GAIN;
            end else if (wr_en[c] && open_w) begin
               if (ctrl[c][5:0] == `REG_OFFSET_COMP) begin
                  offset_comp_o[c] <= wdata[c];
               end
               if (ctrl[c][5:0] == `REG_GAIN_COMP) begin
                  gain_comp_o[c] <= wdata[c];
               end
            end
         end

         // Per channel feature word; the converter acts on its value,
         // for instance 0xf100 for raw offset trim or 0x1006 for normal use.
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               feature_o[c] <= `RST_FEATURE;
            end else if (wr_en[c] && open_w && ctrl[c][5:0] == `REG_FEATURE) begin
               feature_o[c] <= wdata[c];
            end
         end
      end
   endgenerate

   // Shared registers; when two channels write in one frame the higher wins.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ref_gain_o <= `RST_REF_GAIN;
         code_word <= `RST_CODE_WORD;
      end else begin
         for (int i = 0; i < `NUM_CH; i++) begin
            if (wr_en[i] && open_w && ctrl[i][5:0] == `REG_REF_GAIN) begin
               ref_gain_o <= wdata[i];
            end
            // The code word itself is always writable, otherwise it could
            // never be opened.
            if (wr_en[i] && ctrl[i][5:0] == `REG_CODE_WORD) begin
               code_word <= wdata[i];
            end
         end
      end
   end

   // Lock state, visible to the converter.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         unlocked_o <= 1'b0;
      end else begin
         unlocked_o <= open_w;
      end
   end

   // Each output frame is answered by exactly one input frame next cycle.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         link.in_image <= '0;
         link.in_valid <= 1'b0;
      end else begin
         link.in_valid <= link.out_valid;
         if (link.out_valid) begin
            link.in_image <= next_image;
         end
      end
   end

endmodule : thermo_dev_end

// ### verif/thermo_input_ctrl_status_regaccess_tb.sv
/*
   Testbench: both link ends joined, software side driven over Avalon.
   Assumes the defines header is on the include path.
*/
`timescale 1ns/1ps

module thermo_input_ctrl_status_regaccess_tb;
   import thermo_pkg::*;

   // Type code given to the channel end; the value is arbitrary.
   localparam logic [15:0] TYPE_CODE = 16'h5a3c;

   logic ref_clk_i;
   logic rst_i;
   logic [4:0] av_address_i;
   logic av_read_i;
   logic av_write_i;
   logic [31:0] av_writedata_i;
   logic [31:0] av_readdata_o;
   logic av_waitrequest_o;
   logic irq_o;
   word_arr_t meas_raw_i;
   word_arr_t meas_scaled_i;
   logic [`NUM_CH-1:0] err_i;
   logic [`NUM_CH-1:0] over_i;
   logic [`NUM_CH-1:0] under_i;
   word_arr_t offset_comp_o;
   word_arr_t gain_comp_o;
   word_arr_t feature_o;
   logic [15:0] ref_gain_o;
   logic unlocked_o;
   int error_cnt;
   int checks;
   logic [31:0] q;
   logic [7:0] fb;

`define CHK(what, exp, got) \
   checks++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
   end

   thermo_link_if link ();

   thermo_dev_end #(.TYPE_CODE(TYPE_CODE)) i_thermo_dev_end (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .link(link), .meas_raw_i(meas_raw_i), .meas_scaled_i(meas_scaled_i),
      .err_i(err_i), .over_i(over_i), .under_i(under_i), .offset_comp_o(offset_comp_o),
      .gain_comp_o(gain_comp_o), .feature_o(feature_o), .ref_gain_o(ref_gain_o),
      .unlocked_o(unlocked_o));

   thermo_ctl_end i_thermo_ctl_end (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .av_address_i(av_address_i), .av_read_i(av_read_i), .av_write_i(av_write_i),
      .av_writedata_i(av_writedata_i), .av_readdata_o(av_readdata_o),
      .av_waitrequest_o(av_waitrequest_o), .irq_o(irq_o), .link(link));

   thermo_link_monitor #(.TYPE_CODE(TYPE_CODE)) i_thermo_link_monitor (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .out_image(link.out_image), .out_valid(link.out_valid),
      .align(link.align), .big_end(link.big_end), .in_image(link.in_image),
      .in_valid(link.in_valid));

   // Free-running 200 MHz clock.
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Mismatches %0d, checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   // One Avalon access; holds the request until waitrequest is seen low.
   task automatic av_acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      av_address_i <= a;
      av_write_i <= wr;
      av_read_i <= !wr;
      av_writedata_i <= d;
      do @(posedge ref_clk_i);
      while (av_waitrequest_o !== 1'b0);
      q = av_readdata_o;
      av_read_i <= 1'b0;
      av_write_i <= 1'b0;
   endtask : av_acc

   // Runs one register command and leaves the final status word in q.
   task automatic cmd(input logic ch, input logic wr, input logic [5:0] a,
                      input logic [15:0] d);
      av_acc(1'b1, `AV_WDATA, {16'h0000, d});
      av_acc(1'b1, `AV_CMD, {1'b1, 22'h000000, ch, 1'b0, wr, a});
      do av_acc(1'b0, `AV_STATUS, 32'h0);
      while (q[0] !== 1'b0);
   endtask : cmd

   // Generous bound; the whole sequence needs a few hundred cycles.
   initial begin
      repeat (30000) @(posedge ref_clk_i);
      error_cnt++;
      stop_test();
   end

   // Main sequence.
   initial begin
      rst_i = 1'b1;
      av_address_i = 5'h00;
      av_read_i = 1'b0;
      av_write_i = 1'b0;
      av_writedata_i = 32'h0;
      meas_raw_i = {16'h2222, 16'h1111};
      meas_scaled_i = {16'h4455, 16'h3333};
      err_i = 2'b00;
      over_i = 2'b00;
      under_i = 2'b00;
      error_cnt = 0;
      checks = 0;
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      cmd(1'b0, 1'b0, `REG_TYPE_CODE, 16'h0);
      `CHK("type code", {TYPE_CODE, 8'h88}, q[31:8])
      cmd(1'b1, 1'b0, 6'h3f, 16'h0);
      `CHK("last register", {16'h0000, 8'hbf}, q[31:8])
      cmd(1'b0, 1'b1, `REG_OFFSET_COMP, 16'h0042);
      `CHK("locked offset", 16'h0000, offset_comp_o[0])
      cmd(1'b0, 1'b1, `REG_CODE_WORD, 16'h1235);
      `CHK("code word ack", {16'h0000, 8'h9f}, q[31:8])
      `CHK("unlocked", 1'b1, unlocked_o)
      cmd(1'b0, 1'b1, `REG_OFFSET_COMP, 16'h0042);
      `CHK("offset ch0", 16'h0042, offset_comp_o[0])
      `CHK("offset ch1", 16'h0000, offset_comp_o[1])
      cmd(1'b1, 1'b1, `REG_GAIN_COMP, 16'h0123);
      `CHK("gain pair", {16'h0123, 16'h0100}, gain_comp_o)
      cmd(1'b0, 1'b0, `REG_OFFSET_COMP, 16'h0);
      `CHK("offset read", 16'h0042, q[31:16])
      `CHK("offset kept", 16'h0042, offset_comp_o[0])
      cmd(1'b1, 1'b1, `REG_REF_GAIN, 16'h0177);
      cmd(1'b0, 1'b0, `REG_REF_GAIN, 16'h0);
      `CHK("shared ref gain", 16'h0177, q[31:16])
      `CHK("ref gain out", 16'h0177, ref_gain_o)
      // Range flags reach the status bytes of the right channels.
      @(posedge ref_clk_i);
      err_i <= 2'b01;
      over_i <= 2'b10;
      under_i <= 2'b01;
      repeat (40) @(posedge ref_clk_i);
      av_acc(1'b0, `AV_PDATA0, 32'h0);
      `CHK("pdata ch0", {8'h41, 16'h3333}, q[23:0])
      av_acc(1'b0, `AV_PDATA1, 32'h0);
      `CHK("pdata ch1", {8'h02, 16'h4455}, q[23:0])
      cmd(1'b0, 1'b1, `REG_FEATURE, 16'hf100);
      `CHK("feature pair", {16'h1006, 16'hf100}, feature_o)
      // Every mapping choice: the value must survive and sit where expected.
      for (int c = 0; c < 4; c++) begin
         av_acc(1'b1, `AV_CFG, c);
         repeat (40) @(posedge ref_clk_i);
         `CHK("align", c[0], link.align)
         av_acc(1'b0, `AV_PDATA0, 32'h0);
         `CHK("raw ch0", {8'h41, 16'h1111}, q[23:0])
         fb = c[1] ? 8'h44 : 8'h55;
         `CHK("first byte", fb, link.in_image[1][c[0] ? 2 : 1])
      end
      // Interrupt: raised on done when enabled, cleared by a one, masked off.
      @(posedge ref_clk_i);
      err_i <= 2'b00;
      av_acc(1'b1, `AV_IRQ_STAT, 32'h7);
      av_acc(1'b1, `AV_IRQ_MASK, 32'h1);
      cmd(1'b0, 1'b0, `REG_TYPE_CODE, 16'h0);
      repeat (3) @(posedge ref_clk_i);
      `CHK("irq raised", 1'b1, irq_o)
      av_acc(1'b1, `AV_IRQ_STAT, 32'h1);
      repeat (3) @(posedge ref_clk_i);
      `CHK("irq cleared", 1'b0, irq_o)
      av_acc(1'b1, `AV_IRQ_MASK, 32'h0);
      cmd(1'b0, 1'b0, `REG_TYPE_CODE, 16'h0);
      repeat (3) @(posedge ref_clk_i);
      `CHK("irq masked", 1'b0, irq_o)
      av_acc(1'b0, `AV_IRQ_STAT, 32'h0);
      `CHK("done sticky", 1'b1, q[0])
      stop_test();
   end

endmodule : thermo_input_ctrl_status_regaccess_tb

// ### verif/thermo_link_monitor.sv
/*
   Checker for the process image link between the coupler end and the
   channel end. Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module thermo_link_monitor
   import thermo_pkg::*;
#(
   // Type code that the channel end was built with.
   parameter logic [15:0] TYPE_CODE = 16'h1234
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire image_t out_image,
   input wire logic out_valid,
   input wire logic align,
   input wire logic big_end,
   input wire image_t in_image,
   input wire logic in_valid
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   // Head byte for channel 0; it holds until the next frame.
   logic [7:0] head;
   assign head = out_image[0][0];

   // Quiet stretch between two frames.
   sequence quiet8;
      !out_valid [*8];
   endsequence

   chk_answer_next: assert property (out_valid |=> in_valid)
      else $error("frame not answered next cycle");
   chk_no_spurious: assert property (!out_valid |=> !in_valid)
      else $error("answer without frame");
   chk_frame_gap: assert property (out_valid |=> quiet8 ##8 out_valid)
      else $error("frame spacing wrong");
   chk_proc_status: assert property (in_valid && !head[7] |->
      in_image[0][0][7] == 1'b0 && in_image[0][0][5:2] == 4'h0)
      else $error("process status byte bits wrong");
   chk_reg_echo: assert property (in_valid && head[7] |->
      in_image[0][0] == {2'b10, head[5:0]})
      else $error("register status byte wrong");
   chk_write_zero: assert property (in_valid && head[7:6] == 2'b11 |->
      in_image[0][3:1] == 24'h000000)
      else $error("write answer data not zero");
   // An answer is packed with the mapping seen one cycle before it shows.
   chk_pad_byte: assert property (in_valid |->
      ($past(align) ? in_image[0][1] : in_image[0][3]) == 8'h00)
      else $error("reserved byte not zero");
   chk_type_read: assert property (in_valid && head == 8'h88 && !$past(align) &&
      !$past(big_end) |-> {in_image[0][2], in_image[0][1]} == TYPE_CODE)
      else $error("type code wrong");
   chk_img_hold: assert property (!in_valid |-> $stable(in_image))
      else $error("input image changed between frames");

endmodule : thermo_link_monitor
